//--- hw/cmg_map.svh
`ifndef CMG_MAP_SVH
`define CMG_MAP_SVH

// register byte offsets
`define CMG_OFS_CTRL 8'h00
`define CMG_OFS_DIV 8'h04
`define CMG_OFS_FX 8'h08
`define CMG_OFS_PHASE 8'h0C
`define CMG_OFS_STATUS 8'h10
`define CMG_OFS_PERIOD 8'h14
`define CMG_OFS_BUF_EN 8'h18
`define CMG_OFS_BUF_GATE 8'h1C
`define CMG_OFS_BUF_FALL 8'h20

// field positions
`define CMG_CTRL_FB 0
`define CMG_CTRL_HF 1
`define CMG_CTRL_VAR 2
`define CMG_FX_D_LSB 8
`define CMG_STAT_LOCK 8

// reset values
`define CMG_DIV_RST 6'h04
`define CMG_M_RST 8'h04
`define CMG_D_RST 8'h01
`define CMG_PHASE_RST 9'h000

// divide factor in half steps
`define CMG_DIV_MIN 6'h03
`define CMG_DIV_HALF_TOP 6'h10
`define CMG_DIV_MAX 6'h20
`define CMG_PHASE_MAX 14'sh00FF

// timing
`define CMG_CLK_NS 50
`define CMG_STOP_NS 10000
`define CMG_STOP_CYC 12'((`CMG_STOP_NS + `CMG_CLK_NS - 1) / `CMG_CLK_NS)
`define CMG_FINE_NS 3200
`define CMG_FINE_CYC 13'(`CMG_FINE_NS / `CMG_CLK_NS)
`define CMG_LOCK_N 3'h3
`define CMG_NBUF 16

`endif

//--- hw/cmg_pkg.sv
package cmg_pkg;

    typedef struct packed {
        logic var_mode;
        logic hf_mode;
        logic fb_used;
    } cmg_ctrl_t;

    typedef struct packed {
        logic [4:0] unused;
        logic fx_stopped;
        logic in_stopped;
        logic overflow;
    } cmg_status_t;

    typedef struct packed {
        logic zero_phase_out;
        logic quarter_phase_out;
        logic half_phase_out;
        logic three_quarter_phase_out;
        logic double_rate_out;
        logic double_rate_inverted_out;
        logic divided_out;
        logic synthesized_out;
        logic synthesized_inverted_out;
    } cmg_clk_t;

    typedef enum logic {CMG_MUX_RUN, CMG_MUX_HOLD} cmg_mux_st_t;

endpackage

//--- hw/cmg_clock_manager.sv
// How it works
// R1 - status flags overflow and stopped clocks.
// R2 - phase counter slips to align outputs to input.
// R3 - user feeds back a de-skew output.
// R4 - double-rate outputs run at twice input rate.
// R5 - divide by 1.5 to 8 in halves, or 9 to 16.
// R6 - synth rate is input times M over D.
// R7 - inverted outputs lag by half a period.
// R8 - synthesis outputs keep 50/50 duty.
// R9 - coarse outputs spaced a quarter period apart.
// R10 - high-frequency mode drops four outputs.
// R11 - fine offset shifts all nine outputs.
// R12 - shift request steps phase, then completes.
// R13 - phase is signed over 256, -255..+255.
// R14 - variable mode gets half the line span.
// R15 - enable high before rise passes the pulse.
// R16 - enable low before rise holds output low.
// R17 - falling option inverts clock sense only.
// R18 - mux picks input one when select high.
// R19 - switch holds low until new clock falls.
// R20 - no short pulses during switchover.
// R21 - sixteen buffers; disabled ones stay static.
// R22 - lock needs every enabled function locked.
// R23 - manager reset restores initial state.
// R24 - user awaits shift complete per request.
// R25 - mux select synchronised before use.
//
// The implementer's own choices: the placing of the registers and the APB register port.
module cmg_clock_manager (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic manager_reset,
    input wire logic input_clock,
    input wire logic feedback_clock,
    input wire logic shift_clock,
    input wire logic shift_request,
    input wire logic shift_direction,
    output logic shift_complete,
    output logic locked,
    output cmg_pkg::cmg_status_t status,
    output cmg_pkg::cmg_clk_t clk_out,
    input wire logic [15:0] mux_input_zero,
    input wire logic [15:0] mux_input_one,
    input wire logic [15:0] mux_select,
    input wire logic [15:0] gate_enable,
    output logic [15:0] global_out
);
`include "cmg_map.svh"

    ////////////////////////////////////////////////////////////////////////
    function automatic logic signed [13:0] cmg_wrap(input logic signed [13:0] x,
                                                    input logic [11:0] p);
        logic signed [13:0] ps;
        logic signed [13:0] hp;
        ps = $signed({2'h0, p});
        hp = $signed({3'h0, p[11:1]});
        cmg_wrap = x;
        if (x > hp)
        begin
            cmg_wrap = x - ps;
        end
        else if (x <= -hp)
        begin
            cmg_wrap = x + ps;
        end
    endfunction

    function automatic logic signed [13:0] cmg_frac(input logic signed [8:0] ph,
                                                    input logic [11:0] p);
        logic signed [22:0] prod;
        prod = ph * $signed({1'h0, p});
        cmg_frac = 14'(prod >>> 8);
    endfunction

    function automatic logic cmg_fits(input logic signed [8:0] ph, input logic [11:0] p,
                                      input logic [12:0] lim);
        logic signed [13:0] f;
        logic signed [13:0] l;
        f = cmg_frac(ph, p);
        l = $signed({1'h0, lim});
        cmg_fits = (f <= l) && (f >= -l); // [R13]
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register file
    cmg_pkg::cmg_ctrl_t ctrl_ff;
    logic [5:0] div_ff;
    logic [7:0] fxm_ff;
    logic [7:0] fxd_ff;
    logic signed [8:0] phcfg_ff;
    logic [15:0] buf_en_ff;
    logic [15:0] buf_gate_ff;
    logic [15:0] buf_fall_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic [31:0] rdata;
    logic hit;
    logic wr_acc;
    logic [5:0] wdiv;
    logic signed [13:0] wph;

    // manager state
    logic in_q_ff;
    logic fb_q_ff;
    logic sc_q_ff;
    logic [11:0] since_ff;
    logic [11:0] per_ff;
    logic [11:0] per_prev_ff;
    logic [11:0] ph_ff;
    logic [11:0] nxt_ph;
    logic [2:0] good_ff;
    logic sync_ff;
    logic [16:0] dv_ff;
    logic [19:0] acc_ff;
    logic fx_ff;
    logic [11:0] fx_idle_ff;
    logic signed [8:0] phase_ff;
    logic ovf_ff;
    logic pend_ff;
    logic done_ff;
    logic locked_ff;
    cmg_pkg::cmg_status_t status_ff;
    cmg_pkg::cmg_clk_t clk_ff;
    cmg_pkg::cmg_clk_t nxt_clk;

    logic in_rise;
    logic fb_rise;
    logic sc_rise;
    logic in_stop;
    logic fx_stop;
    logic [12:0] limit;
    logic signed [13:0] off;
    logic signed [13:0] err;
    logic evt;
    logic [1:0] step;
    logic signed [8:0] cand;
    logic [16:0] dvp;
    logic [19:0] fx_mod;
    logic [20:0] fx_sum;

    assign wr_acc = psel && penable && pwrite;
    assign wdiv = pwdata[5:0];
    assign wph = $signed(pwdata[13:0]);

    always_comb
    begin
        hit = 1'h1;
        rdata = '0;
        if (paddr == `CMG_OFS_CTRL)
        begin
            rdata = 32'(ctrl_ff);
        end
        else if (paddr == `CMG_OFS_DIV)
        begin
            rdata = 32'(div_ff);
        end
        else if (paddr == `CMG_OFS_FX)
        begin
            rdata = 32'({fxd_ff, fxm_ff});
        end
        else if (paddr == `CMG_OFS_PHASE)
        begin
            rdata = 32'($unsigned(phase_ff));
        end
        else if (paddr == `CMG_OFS_STATUS)
        begin
            rdata = 32'({locked_ff, status_ff});
        end
        else if (paddr == `CMG_OFS_PERIOD)
        begin
            rdata = 32'(per_ff);
        end
        else if (paddr == `CMG_OFS_BUF_EN)
        begin
            rdata = 32'(buf_en_ff);
        end
        else if (paddr == `CMG_OFS_BUF_GATE)
        begin
            rdata = 32'(buf_gate_ff);
        end
        else if (paddr == `CMG_OFS_BUF_FALL)
        begin
            rdata = 32'(buf_fall_ff);
        end
        else
        begin
            hit = 1'h0;
        end
    end

    // read data taken in setup so it leaves a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= '0;
            pslverr_ff <= 1'h0;
        end
        else if (psel && !penable)
        begin
            prdata_ff <= pwrite ? '0 : rdata;
            pslverr_ff <= !hit;
        end
    end

    // illegal divide, M or D writes keep the old value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= '0;
            div_ff <= `CMG_DIV_RST;
            fxm_ff <= `CMG_M_RST; // [R6]
            fxd_ff <= `CMG_D_RST;
            phcfg_ff <= `CMG_PHASE_RST;
            buf_en_ff <= '0;
            buf_gate_ff <= '0;
            buf_fall_ff <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr == `CMG_OFS_CTRL)
            begin
                ctrl_ff <= pwdata[`CMG_CTRL_VAR:`CMG_CTRL_FB];
            end
            else if (paddr == `CMG_OFS_DIV)
            begin
                if ((wdiv >= `CMG_DIV_MIN && wdiv <= `CMG_DIV_HALF_TOP) ||
                    (wdiv > `CMG_DIV_HALF_TOP && wdiv <= `CMG_DIV_MAX && !wdiv[0])) // [R5]
                begin
                    div_ff <= wdiv;
                end
            end
            else if (paddr == `CMG_OFS_FX)
            begin
                if (pwdata[7:0] != 8'h00 && pwdata[15:8] != 8'h00)
                begin
                    fxm_ff <= pwdata[7:0];
                    fxd_ff <= pwdata[`CMG_FX_D_LSB +: 8];
                end
            end
            else if (paddr == `CMG_OFS_PHASE)
            begin
                if (wph <= `CMG_PHASE_MAX && wph >= -`CMG_PHASE_MAX) // [R13]
                begin
                    phcfg_ff <= wph[8:0];
                end
            end
            else if (paddr == `CMG_OFS_BUF_EN)
            begin
                buf_en_ff <= pwdata[15:0];
            end
            else if (paddr == `CMG_OFS_BUF_GATE)
            begin
                buf_gate_ff <= pwdata[15:0];
            end
            else if (paddr == `CMG_OFS_BUF_FALL)
            begin
                buf_fall_ff <= pwdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // period measurement and stop detection
    assign in_rise = input_clock && !in_q_ff;
    assign fb_rise = feedback_clock && !fb_q_ff;
    assign sc_rise = shift_clock && !sc_q_ff;
    assign in_stop = since_ff >= `CMG_STOP_CYC;
    assign fx_stop = fx_idle_ff >= `CMG_STOP_CYC;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_q_ff <= 1'h0;
            fb_q_ff <= 1'h0;
            sc_q_ff <= 1'h0;
            since_ff <= '0;
            per_ff <= '0;
            per_prev_ff <= '0;
        end
        else
        begin
            in_q_ff <= input_clock;
            fb_q_ff <= feedback_clock;
            sc_q_ff <= shift_clock;
            since_ff <= in_rise ? '0 : (since_ff == '1 ? since_ff : since_ff + 12'h001);
            if (manager_reset || in_stop) // [R23]
            begin
                per_ff <= '0;
                per_prev_ff <= '0;
            end
            else if (in_rise)
            begin
                per_ff <= since_ff + 12'h001;
                per_prev_ff <= per_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alignment of feedback (or input) to target skew
    assign limit = ctrl_ff.var_mode ? (`CMG_FINE_CYC >> 1) : `CMG_FINE_CYC; // [R14]
    assign off = cmg_frac(phase_ff, per_ff); // [R11]
    assign evt = ctrl_ff.fb_used ? fb_rise : in_rise; // [R3]

    always_comb
    begin
        logic [12:0] sum;
        logic [12:0] tmp;
        sum = '0;
        tmp = '0;
        if (ctrl_ff.fb_used)
        begin
            err = cmg_wrap($signed({2'h0, since_ff}) - off, per_ff);
        end
        else
        begin
            err = -cmg_wrap($signed({2'h0, ph_ff}) + off, per_ff);
        end
        step = 2'h1;
        if (evt && err > 14'sh0000)
        begin
            step = 2'h2; // [R2]
        end
        else if (evt && err < 14'sh0000)
        begin
            step = 2'h0; // [R2]
        end
        sum = {1'h0, ph_ff} + {11'h000, step};
        tmp = sum - {1'h0, per_ff};
        if (per_ff == '0)
        begin
            nxt_ph = '0;
        end
        else if (sum < {1'h0, per_ff})
        begin
            nxt_ph = sum[11:0];
        end
        else
        begin
            nxt_ph = (tmp >= {1'h0, per_ff}) ? '0 : tmp[11:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph_ff <= '0;
            good_ff <= '0;
            sync_ff <= 1'h0;
            locked_ff <= 1'h0;
        end
        else if (manager_reset) // [R23]
        begin
            ph_ff <= '0;
            good_ff <= '0;
            sync_ff <= 1'h0;
            locked_ff <= 1'h0;
        end
        else
        begin
            ph_ff <= nxt_ph;
            if (in_stop || (evt && err != 14'sh0000))
            begin
                good_ff <= '0;
            end
            else if (evt && good_ff != `CMG_LOCK_N)
            begin
                good_ff <= good_ff + 3'h1;
            end
            locked_ff <= good_ff == `CMG_LOCK_N && per_ff == per_prev_ff && per_ff != '0 &&
                         !in_stop && !fx_stop; // [R22]
            // derived clocks start at a zero-phase rise
            sync_ff <= locked_ff && (sync_ff || ph_ff == per_ff - 12'h001); // [R2]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divider and M/D synthesis, both restarted at the zero-phase edge
    assign dvp = 17'((18'(per_ff) * 18'(div_ff)) >> 1); // [R5]
    assign fx_mod = 20'(per_ff) * 20'(fxd_ff); // [R6]
    assign fx_sum = {1'h0, acc_ff} + {12'h000, fxm_ff, 1'h0};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dv_ff <= '0;
            acc_ff <= '0;
            fx_ff <= 1'h1;
            fx_idle_ff <= '0;
        end
        else if (!sync_ff || manager_reset)
        begin
            dv_ff <= '0;
            acc_ff <= '0;
            fx_ff <= 1'h1;
            fx_idle_ff <= '0;
        end
        else
        begin
            dv_ff <= (dv_ff >= dvp - 17'h00001) ? '0 : dv_ff + 17'h00001;
            // accumulator toggles at 2M/(P*D) per cycle, so frequency is in*M/D
            if (fx_sum >= {1'h0, fx_mod})
            begin
                acc_ff <= 20'(fx_sum - {1'h0, fx_mod});
                fx_ff <= !fx_ff; // [R8]
                fx_idle_ff <= '0;
            end
            else
            begin
                acc_ff <= fx_sum[19:0];
                fx_idle_ff <= fx_stop ? fx_idle_ff : fx_idle_ff + 12'h001;
            end
        end
    end

    always_comb
    begin
        logic [11:0] hp;
        logic [11:0] q4;
        logic [12:0] qd;
        logic [11:0] dd;
        logic run;
        logic hf;
        hp = per_ff >> 1;
        q4 = per_ff >> 2;
        qd = (ph_ff >= q4) ? 13'(ph_ff - q4) : 13'({1'h0, ph_ff} + {1'h0, per_ff} - {1'h0, q4});
        dd = (ph_ff >= hp) ? ph_ff - hp : ph_ff;
        run = per_ff != '0;
        hf = ctrl_ff.hf_mode;
        nxt_clk.zero_phase_out = run && ph_ff < hp; // [R9]
        nxt_clk.half_phase_out = run && !(ph_ff < hp);
        nxt_clk.quarter_phase_out = run && !hf && qd < {1'h0, hp}; // [R10]
        nxt_clk.three_quarter_phase_out = run && !hf && !(qd < {1'h0, hp});
        nxt_clk.double_rate_out = run && !hf && dd < q4; // [R4]
        nxt_clk.double_rate_inverted_out = run && !hf && !(dd < q4); // [R7]
        nxt_clk.divided_out = sync_ff && dv_ff < (dvp >> 1); // [R8]
        nxt_clk.synthesized_out = sync_ff && fx_ff;
        nxt_clk.synthesized_inverted_out = sync_ff && !fx_ff; // [R7]
    end

    ////////////////////////////////////////////////////////////////////////
    // fine phase: fixed follows software, variable steps on the shift port
    always_comb
    begin
        cand = shift_direction ? phase_ff + 9'h001 : phase_ff - 9'h001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_ff <= `CMG_PHASE_RST;
            ovf_ff <= 1'h0;
            pend_ff <= 1'h0;
            done_ff <= 1'h0;
        end
        else if (manager_reset || !ctrl_ff.var_mode)
        begin
            phase_ff <= phcfg_ff;
            ovf_ff <= !cmg_fits(phcfg_ff, per_ff, `CMG_FINE_CYC); // [R14]
            pend_ff <= 1'h0;
            done_ff <= 1'h0;
        end
        else if (sc_rise)
        begin
            // completion one shift clock later, held for one shift clock period
            done_ff <= pend_ff; // [R12]
            pend_ff <= shift_request;
            if (shift_request)
            begin
                if ($signed(14'(cand)) <= `CMG_PHASE_MAX && $signed(14'(cand)) >=
                    -`CMG_PHASE_MAX && !(phase_ff == 9'h0FF && shift_direction) &&
                    cmg_fits(cand, per_ff, limit)) // [R13]
                begin
                    phase_ff <= cand;
                    ovf_ff <= 1'h0;
                end
                else
                begin
                    ovf_ff <= 1'h1; // [R1]
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_ff <= '0;
            clk_ff <= '0;
        end
        else
        begin
            status_ff <= '{unused: 5'h00, fx_stopped: !sync_ff || fx_stop,
                           in_stopped: in_stop, overflow: ovf_ff}; // [R1]
            clk_ff <= manager_reset ? '0 : nxt_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // global buffers, gate or glitchless mux each
    logic [15:0] nz_q_ff;
    logic [15:0] no_q_ff;
    logic [15:0] pass_ff;
    logic [15:0] sel1_ff;
    logic [15:0] sel2_ff;
    logic [15:0] cur_ff;
    cmg_pkg::cmg_mux_st_t st_ff [16];
    cmg_pkg::cmg_mux_st_t nxt_st [16];
    logic [15:0] nxt_pass;
    logic [15:0] nxt_cur;
    logic [15:0] nxt_out;
    logic [15:0] gout_ff;

    always_comb
    begin
        logic a;
        logic b;
        logic lvl;
        logic nfall;
        logic core;
        a = 1'h0;
        b = 1'h0;
        lvl = 1'h0;
        nfall = 1'h0;
        core = 1'h0;
        for (int i = 0; i < `CMG_NBUF; i++)
        begin
            a = mux_input_zero[i] ^ buf_fall_ff[i]; // [R17]
            b = mux_input_one[i] ^ buf_fall_ff[i];
            lvl = cur_ff[i] ? b : a; // [R18]
            nfall = cur_ff[i] ? (nz_q_ff[i] && !a) : (no_q_ff[i] && !b);
            nxt_st[i] = st_ff[i];
            nxt_cur[i] = cur_ff[i];
            // enable taken at the rise only, so no pulse is cut
            nxt_pass[i] = (a && !nz_q_ff[i]) ? gate_enable[i] : pass_ff[i]; // [R15]
            if (buf_gate_ff[i])
            begin
                core = a && nxt_pass[i]; // [R16]
            end
            else if (st_ff[i] == cmg_pkg::CMG_MUX_RUN)
            begin
                core = lvl;
                if (sel2_ff[i] != cur_ff[i] && !lvl) // [R19]
                begin
                    nxt_st[i] = cmg_pkg::CMG_MUX_HOLD;
                end
            end
            else
            begin
                core = 1'h0; // [R20]
                if (nfall)
                begin
                    nxt_st[i] = cmg_pkg::CMG_MUX_RUN;
                    nxt_cur[i] = !cur_ff[i]; // [R19]
                end
            end
            nxt_out[i] = (buf_en_ff[i] && core) ^ buf_fall_ff[i]; // [R21]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nz_q_ff <= '0;
            no_q_ff <= '0;
            pass_ff <= '0;
            sel1_ff <= '0;
            sel2_ff <= '0;
            cur_ff <= '0;
            gout_ff <= '0;
            for (int i = 0; i < `CMG_NBUF; i++)
            begin
                st_ff[i] <= cmg_pkg::CMG_MUX_RUN;
            end
        end
        else
        begin
            nz_q_ff <= mux_input_zero ^ buf_fall_ff;
            no_q_ff <= mux_input_one ^ buf_fall_ff;
            pass_ff <= nxt_pass;
            sel1_ff <= mux_select; // [R25]
            sel2_ff <= sel1_ff;
            cur_ff <= nxt_cur;
            gout_ff <= nxt_out;
            for (int i = 0; i < `CMG_NBUF; i++)
            begin
                st_ff[i] <= nxt_st[i];
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'h1;
    assign pslverr = pslverr_ff && psel && penable;
    assign shift_complete = done_ff;
    assign locked = locked_ff;
    assign status = status_ff;
    assign clk_out = clk_ff;
    assign global_out = gout_ff;

endmodule // cmg_clock_manager

//--- tb/cmg_props.sv
module cmg_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic manager_reset,
    input wire logic shift_clock,
    input wire logic shift_complete,
    input wire logic locked,
    input wire cmg_pkg::cmg_status_t status,
    input wire cmg_pkg::cmg_clk_t clk_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_spare_zero: assert property (status.unused == 5'h00) else $error("spare set");
    a_ready_tied: assert property (pready) else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata");
    a_mreset_lock: assert property (manager_reset |=> !locked) else $error("lock kept");
    a_mreset_clk: assert property (manager_reset |=> clk_out == '0) else $error("clk kept");
    a_done_edge: assert property ($rose(shift_complete) |-> $past(shift_clock)) else $error("done");
    a_lock_input: assert property ($rose(locked) |-> !status.in_stopped) else $error("lock");
endmodule // cmg_props

//--- tb/cmg_partner.sv
module cmg_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic zero_phase_out,
    output logic input_clock,
    output logic feedback_clock,
    output logic shift_clock,
    output logic [15:0] mux_input_zero,
    output logic [15:0] mux_input_one
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_ff;
    // sources far slower than pclk
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= 8'h00;
        end
        else
        begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
    assign input_clock = cnt_ff[4];
    assign feedback_clock = zero_phase_out;
    assign shift_clock = cnt_ff[2];
    assign mux_input_zero = {16{cnt_ff[3]}};
    assign mux_input_one = {16{cnt_ff[1]}};
endmodule // cmg_partner

//--- tb/testbench.sv
`include "cmg_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic manager_reset = 1'b0, shift_request = 1'b0, shift_direction = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, lfsr_v = 32'h00014E93;
    logic pready, pslverr, er, shift_complete, locked, input_clock, feedback_clock, shift_clock;
    logic [15:0] mux_input_zero, mux_input_one, global_out;
    logic [15:0] mux_select = 16'h0000, gate_enable = 16'h0000;
    logic [5:0] div_v = 6'h04;
    cmg_pkg::cmg_status_t status;
    cmg_pkg::cmg_clk_t clk_out;
    wire logic [9:0] mon = {global_out[0], clk_out};
    int err_total = 0, checks_done = 0;
    cmg_clock_manager cmg_clock_manager_inst (.*);
    cmg_partner cmg_partner_inst (.pclk, .presetn, .zero_phase_out(clk_out.zero_phase_out),
        .input_clock, .feedback_clock, .shift_clock, .mux_input_zero, .mux_input_one);
    initial
    begin
        forever #25 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] rnd();
        lfsr_v = {lfsr_v[30:0], lfsr_v[31] ^ lfsr_v[21] ^ lfsr_v[1] ^ lfsr_v[0]};
        return lfsr_v[5:0];
    endfunction
    function automatic logic [5:0] div_exp(input logic [5:0] v, input logic [5:0] o);
        return ((v >= 6'h03 && v <= 6'h10) || (v >= 6'h12 && v <= 6'h20 && !v[0])) ? v : o;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    // switchover may cost one edge
    task automatic edges(input int b, input int e, input string n);
        int c = 0;
        logic p;
        repeat (16) @(posedge pclk);
        p = mon[b];
        repeat (256)
        begin
            @(posedge pclk);
            c += int'(mon[b] && !p);
            p = mon[b];
        end
        if (c < e - 1 || c > e + 1)
            chk(n, e, c);
        else
            checks_done++;
    endtask
    task automatic shift(input logic dir);
        shift_request <= 1'b1;
        shift_direction <= dir;
        @(posedge shift_clock);
        @(posedge pclk);
        shift_request <= 1'b0;
        for (int k = 0; k < 64 && shift_complete !== 1'b1; k++) @(posedge pclk);
        chk("shift done", 32'h1, {31'h0, shift_complete});
        repeat (20) @(posedge pclk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [5:0] v;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`CMG_OFS_DIV, 32'h4, "div reset");
        rdc(`CMG_OFS_FX, 32'h0104, "fx reset");
        rdc(`CMG_OFS_STATUS, 32'h4, "status reset");
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        for (int i = 0; i < 8; i++)
        begin
            v = (i == 0) ? 6'h11 : (i == 1) ? 6'h20 : (i == 2) ? 6'h02 : rnd();
            apb(1'b1, `CMG_OFS_DIV, {26'h0, v});
            div_v = div_exp(v, div_v);
            rdc(`CMG_OFS_DIV, {26'h0, div_v}, "div value");
        end
        apb(1'b1, `CMG_OFS_DIV, 32'h4);
        $display("test registers done");
        apb(1'b1, `CMG_OFS_CTRL, 32'h1);
        for (int k = 0; k < 3000 && locked !== 1'b1; k++) @(posedge pclk);
        chk("locked", 32'h1, {31'h0, locked});
        rdc(`CMG_OFS_PERIOD, 32'h20, "period");
        edges(4, 16, "double");
        edges(3, 16, "double inv");
        edges(1, 32, "synth");
        edges(0, 32, "synth inv");
        edges(2, 4, "divided");
        edges(7, 8, "quarter");
        $display("test clocks done");
        apb(1'b1, `CMG_OFS_CTRL, 32'h5);
        shift(1'b1);
        rdc(`CMG_OFS_PHASE, 32'h1, "phase up");
        shift(1'b0);
        shift(1'b0);
        apb(1'b0, `CMG_OFS_PHASE, 32'h0);
        chk("phase down", 32'h1FF, {23'h0, rd[8:0]});
        manager_reset <= 1'b1;
        repeat (3) @(posedge pclk);
        manager_reset <= 1'b0;
        $display("test shift done");
        apb(1'b1, `CMG_OFS_BUF_EN, 32'h1);
        apb(1'b1, `CMG_OFS_BUF_GATE, 32'h1);
        edges(9, 0, "gate off");
        gate_enable <= 16'hFFFF;
        edges(9, 16, "gate on");
        apb(1'b1, `CMG_OFS_BUF_GATE, 32'h0);
        edges(9, 16, "mux zero");
        mux_select <= 16'hFFFF;
        edges(9, 64, "mux one");
        $display("test buffers done");
        final_report();
    end
    initial
    begin
        #(40000 * 50);
        err_total++;
        final_report();
    end
endmodule // testbench
bind cmg_clock_manager cmg_props cmg_props_inst (.*);
